// >>> core/flj_judge.sv
// top: five-level limit judge with four banks and two-point capture
`timescale 1ns/1ps
`default_nettype none
module flj_judge
  import flj_pkg::*;
#(
  parameter int HOLD_CYC = BANK_HOLD_CYC
)
(
  input  wire logic      ref_clk,
  input  wire logic      rst,
  input  wire flj_meas_s meas,
  input  wire logic      five_output_mode,
  input  wire logic      shared_preset_point,
  input  wire logic      key_locked,
  input  wire logic      bank_sel_a,
  input  wire logic      bank_sel_b,
  input  wire logic      btn_mode_held,
  input  wire logic      btn_up,
  input  wire logic      btn_down,
  input  wire logic      btn_set,
  input  wire flj_sel_e  edit_sel,
  input  wire logic      nv_bank_valid,
  input  wire flj_bank_t nv_bank,
  output flj_crit_s      crit_ff,
  output flj_val_t       disp_ff,
  output logic           disp_invalid_ff,
  output flj_bank_t      active_bank_ff,
  output logic           nv_bank_wr_ff,
  output logic           cal_refused_ff,
  output flj_val_t       preset_point_ff
);

  // per-bank storage
  // six words a bank in flops: at four banks the cost is small, and every
  // word of the active bank is readable in the same cycle as the judge;
  // a memory macro would add a read cycle between a bank switch and a level
  flj_val_t ua_ff  [NUM_BANKS];  // upper alarm limit
  flj_val_t hi_ff  [NUM_BANKS];  // high limit
  flj_val_t lo_ff  [NUM_BANKS];  // low limit
  flj_val_t la_ff  [NUM_BANKS];  // lower alarm limit
  flj_val_t ppt_ff [NUM_BANKS];  // preset point
  flj_val_t pvl_ff [NUM_BANKS];  // preset value
  flj_val_t ppt_shared_ff;       // preset point common to all banks

  // two-point capture state
  // one pairing flag serves every item: switching the item between the two
  // presses would pair readings meant for different limits
  logic     cap_pending_ff;      // first point taken
  flj_val_t cap_first_ff;        // first captured value
  logic     nv_loaded_ff;        // stored bank restored once

  // bank filter outputs
  // ext_stable marks only levels that stood for the whole hold time; ext_bank follows every level
  logic      ext_stable;
  flj_bank_t ext_bank;

  // working values
  flj_bank_t  bank;
  flj_val_t   ua, hi, lo, la, pvl;
  logic signed [VAL_W:0] sum_w;
  flj_val_t   pv;
  flj_val_t   sel_val, nxt_sel_val;
  logic signed [VAL_W:0] mid_w;
  logic       sel_is_alarm;
  logic       edit_ok;
  logic       up_only, down_only;
  // order-fault flags of the active bank
  logic       alarms_crossed;    // upper alarm set below lower alarm
  logic       high_masked;       // upper alarm set below high
  logic       low_masked;        // low set below lower alarm
  logic       band_open;         // high at or above low

  // bank-select lines qualified by hold time; a bounce on a line restarts
  // the count, so a short glitch can never move the active bank
  flj_bank_filter #(
    .HOLD_CYC   (HOLD_CYC)
  ) flj_bank_filter_inst (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .bank_sel_a (bank_sel_a),
    .bank_sel_b (bank_sel_b),
    .stable_ff  (ext_stable),
    .bank_ff    (ext_bank)
  );

  // active bank supplies all settings
  // the five words the judge reads switch in one edge, so no sample is ever
  // judged against a mix of two banks
  assign bank = active_bank_ff;
  assign ua   = ua_ff[bank];
  assign hi   = hi_ff[bank];
  assign lo   = lo_ff[bank];
  assign la   = la_ff[bank];
  assign pvl  = pvl_ff[bank];

  // preset added, result saturated to the display range
  // the sum carries one extra bit so an overflow is seen, not wrapped;
  // concatenations are unsigned, so the bounds are compared as signed
  // values, or every negative sum would pin the display at the top
  always_comb
  begin
    sum_w = {meas.value[VAL_W-1], meas.value} + {pvl[VAL_W-1], pvl};
    if (sum_w > $signed({VAL_MAX[VAL_W-1], VAL_MAX}))
      pv = VAL_MAX; // above the range
    else if (sum_w < $signed({VAL_MIN[VAL_W-1], VAL_MIN}))
      pv = VAL_MIN; // below the range
    else
      pv = sum_w[VAL_W-1:0];
  end

  // alarm limits only reachable in five-output mode
  // the alarm words keep their value outside the mode, so going back to
  // five-output mode brings the old alarm limits back with it
  assign sel_is_alarm = (edit_sel == FLJ_SEL_UA) || (edit_sel == FLJ_SEL_LA);
  assign edit_ok      = !sel_is_alarm || five_output_mode;
  // mode+up is the bank gesture, not an edit
  // both arrows in one cycle cancel rather than guess at the intent
  assign up_only      = btn_up && !btn_down && !btn_mode_held;
  assign down_only    = btn_down && !btn_up && !btn_mode_held;

  // current value of the item being edited
  // with a shared preset point the per-bank copies are hidden, not lost
  always_comb
  begin
    case (edit_sel)
      FLJ_SEL_UA:  sel_val = ua;
      FLJ_SEL_HI:  sel_val = hi;
      FLJ_SEL_LO:  sel_val = lo;
      FLJ_SEL_LA:  sel_val = la;
      FLJ_SEL_PPT: sel_val = shared_preset_point ? ppt_shared_ff : ppt_ff[bank];
      FLJ_SEL_PVL: sel_val = pvl;
      default:     sel_val = '0;
    endcase
  end

  // midpoint of first capture and current raw sample
  // an odd sum rounds toward minus; the raw reading is captured, so the
  // preset does not enter the limit twice
  assign mid_w = ({cap_first_ff[VAL_W-1], cap_first_ff}
                + {meas.value[VAL_W-1], meas.value}) >>> 1;

  // order faults of the active bank; they mask levels, never the alarms
  // themselves, so a crossed alarm pair still shows both sides
  assign alarms_crossed = ua < la;
  assign high_masked    = ua < hi;
  assign low_masked     = lo < la;
  assign band_open      = hi >= lo;

  // next value for the selected item; clamped to range
  // arrows win over set in the same cycle unless the arrow is already at its end; ends saturate, never wrap
  always_comb
  begin
    nxt_sel_val = sel_val;
    if (up_only && sel_val < VAL_MAX)
      nxt_sel_val = sel_val + 1'b1;
    else if (down_only && sel_val > VAL_MIN)
      nxt_sel_val = sel_val - 1'b1;
    else if (btn_set && cap_pending_ff && !meas.invalid)
      nxt_sel_val = mid_w[VAL_W-1:0];
  end

  // two-point capture: first set takes a point, second sets midpoint
  // a refused press leaves the pairing flag alone, so a dashed reading
  // never becomes half of a midpoint
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cap_pending_ff <= 1'b0;
      cap_first_ff   <= '0;
      cal_refused_ff <= 1'b0;
    end
    else
    begin
      cal_refused_ff <= btn_set && (meas.invalid || !edit_ok);
      if (btn_set && edit_ok && !meas.invalid)
      begin
        cap_pending_ff <= !cap_pending_ff;
        cap_first_ff   <= meas.value;
      end
    end
  end

  // per-bank settings storage; writes act at once on the judge
  // only the active bank is written; the other banks hold their words even
  // while an item is being edited
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++)
    begin : g_bank
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          ua_ff[g]  <= UA_RST;
          hi_ff[g]  <= HI_RST;
          lo_ff[g]  <= LO_RST;
          la_ff[g]  <= LA_RST;
          ppt_ff[g] <= PPT_RST;
          pvl_ff[g] <= PVL_RST;
        end
        else if (bank == flj_bank_t'(g) && edit_ok)
        begin
          case (edit_sel)
            FLJ_SEL_UA:  ua_ff[g] <= nxt_sel_val;
            FLJ_SEL_HI:  hi_ff[g] <= nxt_sel_val;
            FLJ_SEL_LO:  lo_ff[g] <= nxt_sel_val;
            FLJ_SEL_LA:  la_ff[g] <= nxt_sel_val;
            FLJ_SEL_PPT:
              if (!shared_preset_point)
                ppt_ff[g] <= nxt_sel_val;
            FLJ_SEL_PVL: pvl_ff[g] <= nxt_sel_val;
            default:     ua_ff[g] <= ua_ff[g];
          endcase
        end
      end
    end
  endgenerate

  // shared preset point
  // written only while shared; per-bank copies survive a switch of mode
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ppt_shared_ff <= PPT_RST;
    else if (shared_preset_point && edit_sel == FLJ_SEL_PPT)
      ppt_shared_ff <= nxt_sel_val;
  end

  // preset point seen by the origin logic
  // registered so the origin logic sees one settled value each cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      preset_point_ff <= PPT_RST;
    else
      preset_point_ff <= shared_preset_point ? ppt_shared_ff : ppt_ff[bank];
  end

  // active bank: restored, stepped by buttons, or external when locked
  // the restore comes first: until it lands, neither buttons nor lines may
  // move the bank, or the stored choice would be lost at power-up;
  // every later change pulses a storage write of the new bank
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      active_bank_ff <= BANK_RST;
      nv_loaded_ff   <= 1'b0;
      nv_bank_wr_ff  <= 1'b0;
    end
    else
    begin
      nv_bank_wr_ff <= 1'b0;
      if (!nv_loaded_ff)
      begin
        // storage restores the bank after power-up
        nv_loaded_ff <= nv_bank_valid;
        if (nv_bank_valid)
          active_bank_ff <= nv_bank;
      end
      else if (key_locked)
      begin
        // mode+up bank step locked, arrows and set still edit; external lines rule; kept after unlock
        if (ext_stable && ext_bank != active_bank_ff)
        begin
          active_bank_ff <= ext_bank;
          nv_bank_wr_ff  <= 1'b1;
        end
      end
      else if (btn_mode_held && btn_up)
      begin
        active_bank_ff <= active_bank_ff + 1'b1;
        nv_bank_wr_ff  <= 1'b1;
      end
    end
  end

  // judge on each new sample; strictly above exceeds
  // dashes clear every level, so a missing reading never looks like a pass;
  // the display follows every sample, dashes included
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      crit_ff         <= '0;
      disp_ff         <= '0;
      disp_invalid_ff <= 1'b1;
    end
    else if (meas.valid)
    begin
      disp_ff         <= pv;
      disp_invalid_ff <= meas.invalid;
      if (meas.invalid)
        crit_ff <= '0; // nothing judged on dashes
      else if (five_output_mode)
      begin
        crit_ff.ua <= pv > ua;
        crit_ff.la <= pv < la;
        crit_ff.hi <= (pv > hi) && !(pv > ua) && !high_masked && !alarms_crossed;
        crit_ff.lo <= (pv < lo) && !(pv < la) && !low_masked && !alarms_crossed;
        crit_ff.go <= !(pv > hi) && !(pv < lo) && band_open && !alarms_crossed
                      && !(pv > ua) && !(pv < la);
      end
      else
      begin
        // three-level mode: alarm outputs stay off
        // the band test still applies, so crossed high and low give no go
        crit_ff.ua <= 1'b0;
        crit_ff.la <= 1'b0;
        crit_ff.hi <= pv > hi;
        crit_ff.lo <= pv < lo;
        crit_ff.go <= !(pv > hi) && !(pv < lo) && band_open;
      end
    end
  end

endmodule // flj_judge
`default_nettype wire

// >>> core/flj_pkg.sv
// package: value formats, defaults and timing constants of the five-level judge
package flj_pkg;

  // values are signed, unit 0.0001, range +/-1999999
  localparam int VAL_W = 22;
  typedef logic signed [VAL_W-1:0] flj_val_t;
  localparam flj_val_t VAL_MAX = 22'sh1E847F;          // 199.9999
  localparam flj_val_t VAL_MIN = -22'sh1E847F;         // -199.9999

  // bank count and select width
  localparam int NUM_BANKS = 4;
  typedef logic [1:0] flj_bank_t;
  localparam flj_bank_t BANK_RST = 2'h0;

  // threshold reset values, unit 0.0001
  localparam flj_val_t UA_RST  = 22'sh011170;          // 7.0000
  localparam flj_val_t HI_RST  = 22'sh00C350;          // 5.0000
  localparam flj_val_t LO_RST  = 22'sh002710;          // 1.0000
  localparam flj_val_t LA_RST  = -22'sh002710;         // -1.0000
  localparam flj_val_t PPT_RST = 22'sh000000;          // preset point
  localparam flj_val_t PVL_RST = 22'sh000000;          // preset value

  // which stored item a button action targets
  typedef enum logic [2:0] {
    FLJ_SEL_UA,
    FLJ_SEL_HI,
    FLJ_SEL_LO,
    FLJ_SEL_LA,
    FLJ_SEL_PPT,
    FLJ_SEL_PVL
  } flj_sel_e;

  // one sample from the measuring front end
  typedef struct packed {
    logic     valid;    // new sample strobe
    logic     invalid;  // raw value shown as dashes
    flj_val_t value;    // raw measured value
  } flj_meas_s;

  // five criterion outputs
  typedef struct packed {
    logic ua;
    logic hi;
    logic go;
    logic lo;
    logic la;
  } flj_crit_s;

  // bank-select input filter: 20 ms hold
  localparam int CLK_HZ      = 200_000_000;
  localparam int BANK_HOLD_MS = 20;
  localparam int BANK_HOLD_CYC = (CLK_HZ / 1000) * BANK_HOLD_MS;
  localparam int HOLD_CNT_W  = 23;

endpackage : flj_pkg

// >>> core/flj_bank_filter.sv
// filter: bank-select lines must stand stable for the hold time
`timescale 1ns/1ps
`default_nettype none
module flj_bank_filter
  import flj_pkg::*;
#(
  parameter int HOLD_CYC = BANK_HOLD_CYC
)
(
  input  wire logic      ref_clk,
  input  wire logic      rst,
  input  wire logic      bank_sel_a,
  input  wire logic      bank_sel_b,
  output logic           stable_ff,
  output flj_bank_t      bank_ff
);

  flj_bank_t              raw;
  flj_bank_t              last_ff;
  logic [HOLD_CNT_W-1:0]  cnt_ff;

  // binary code: line a is bit 0, line b is bit 1
  assign raw = {bank_sel_b, bank_sel_a};

  // restart the count on any level change
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      last_ff <= BANK_RST;
      cnt_ff  <= '0;
    end
    else if (raw != last_ff)
    begin
      last_ff <= raw;
      cnt_ff  <= '0;
    end
    else if (cnt_ff < HOLD_CNT_W'(HOLD_CYC - 1))
    begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // qualified level once held long enough
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stable_ff <= 1'b0;
      bank_ff   <= BANK_RST;
    end
    else
    begin
      stable_ff <= (raw == last_ff) && (cnt_ff >= HOLD_CNT_W'(HOLD_CYC - 1));
      bank_ff   <= last_ff;
    end
  end

endmodule // flj_bank_filter
`default_nettype wire

// >>> testbench/flj_judge_sva.sv
// checker: port-level properties of the five-level judge
`timescale 1ns/1ps
`default_nettype none
module flj_judge_sva
  import flj_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst,
  input wire flj_meas_s meas,
  input wire logic      five_output_mode,
  input wire logic      key_locked,
  input wire logic      btn_mode_held,
  input wire logic      btn_up,
  input wire logic      btn_set,
  input wire flj_sel_e  edit_sel,
  input wire logic      nv_bank_valid,
  input wire flj_crit_s crit_ff,
  input wire logic      disp_invalid_ff,
  input wire flj_bank_t active_bank_ff,
  input wire logic      cal_refused_ff
);
  // one domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  go_alone_a:
    assert property (crit_ff.go |-> !(crit_ff.ua || crit_ff.hi || crit_ff.lo || crit_ff.la))
    else $error("go asserted with another level");
  crit_hold_a:
    assert property (!meas.valid |=> $stable(crit_ff))
    else $error("criteria moved without a sample");
  invalid_clear_a:
    assert property (meas.valid && meas.invalid |=> crit_ff == 5'h00 && disp_invalid_ff)
    else $error("invalid sample left criteria set");
  valid_shown_a:
    assert property (meas.valid && !meas.invalid |=> !disp_invalid_ff)
    else $error("valid sample shown as dashes");
  alarm_off_a:
    assert property (meas.valid && !five_output_mode |=> !crit_ff.ua && !crit_ff.la)
    else $error("alarm level outside five-output mode");
  cal_refuse_a:
    assert property (btn_set && meas.invalid |=> cal_refused_ff)
    else $error("capture on invalid value not refused");
  alarm_lock_a:
    assert property (btn_set && !five_output_mode && edit_sel inside {FLJ_SEL_UA, FLJ_SEL_LA}
                     |=> cal_refused_ff)
    else $error("alarm capture not refused");
  refuse_cause_a:
    assert property (!btn_set |=> !cal_refused_ff)
    else $error("refusal without a set press");
  bank_step_a:
    assert property (btn_mode_held && btn_up && !key_locked && !nv_bank_valid
                     |=> active_bank_ff == flj_bank_t'($past(active_bank_ff) + 2'h1))
    else $error("bank did not advance by one");
  ext_ignored_a:
    assert property (!key_locked && !btn_mode_held && !nv_bank_valid |=> $stable(active_bank_ff))
    else $error("bank changed while unlocked");
endmodule // flj_judge_sva

bind flj_judge flj_judge_sva flj_judge_sva_inst (.ref_clk, .rst, .meas, .five_output_mode,
  .key_locked, .btn_mode_held, .btn_up, .btn_set, .edit_sel, .nv_bank_valid, .crit_ff,
  .disp_invalid_ff, .active_bank_ff, .cal_refused_ff);
`default_nettype wire

// >>> testbench/flj_ctrl_model.sv
// partner: controller side driving the two bank-select lines
`timescale 1ns/1ps
`default_nettype none
module flj_ctrl_model
  import flj_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire flj_bank_t want_bank,
  output logic           bank_sel_a = 1'b0,
  output logic           bank_sel_b = 1'b0
);
  // lines launch just after the edge; callers keep a code until the bank follows, a few cycles past the hold time
  always @(posedge ref_clk)
  begin
    bank_sel_a <= want_bank[0];
    bank_sel_b <= want_bank[1];
  end
endmodule // flj_ctrl_model
`default_nettype wire

// >>> testbench/flj_judge_bench.sv
// bench: self-checking run of the five-level judge
`timescale 1ns/1ps
`default_nettype none
module flj_judge_bench
  import flj_pkg::*;
;
  logic      ref_clk = 1'b0;      // 200 MHz
  logic      rst = 1'b1;          // async reset
  flj_meas_s meas = '0;           // sample stream
  logic      five_mode = 1'b1;    // five-output mode
  logic      key_locked = 1'b0;   // key lock
  logic      mode_held = 1'b0;    // mode button level
  logic      nv_valid = 1'b0;     // stored bank strobe
  logic [2:0] btns = 3'h0;        // set, down, up pulses
  flj_sel_e  edit_sel = FLJ_SEL_UA;
  flj_bank_t want = 2'h0;         // bank asked of the controller
  wire       sel_a;
  wire       sel_b;
  flj_crit_s crit;
  flj_val_t  disp;
  logic      disp_inv;
  flj_bank_t bank;
  logic      nv_wr;
  logic      refused;
  logic      shared = 1'b0;       // one preset point for all banks
  flj_val_t  ppt;                 // preset point in use
  int        bad_count = 0;
  int        total_checks = 0;
  int        wr_seen = 0;         // storage write pulses

  always #2.5 ref_clk = ~ref_clk;
  // count storage writes; the pulse is one cycle wide
  always @(posedge ref_clk)
    if (nv_wr === 1'b1)
      wr_seen <= wr_seen + 1;

  // short hold so external bank steps finish quickly
  flj_judge #(.HOLD_CYC(8)) flj_judge_inst (.ref_clk(ref_clk), .rst(rst), .meas(meas),
    .five_output_mode(five_mode), .shared_preset_point(shared), .key_locked(key_locked),
    .bank_sel_a(sel_a), .bank_sel_b(sel_b), .btn_mode_held(mode_held), .btn_up(btns[0]),
    .btn_down(btns[1]), .btn_set(btns[2]), .edit_sel(edit_sel), .nv_bank_valid(nv_valid),
    .nv_bank(2'h2), .crit_ff(crit), .disp_ff(disp), .disp_invalid_ff(disp_inv),
    .active_bank_ff(bank), .nv_bank_wr_ff(nv_wr), .cal_refused_ff(refused),
    .preset_point_ff(ppt));
  flj_ctrl_model flj_ctrl_model_inst (.ref_clk(ref_clk), .want_bank(want),
    .bank_sel_a(sel_a), .bank_sel_b(sel_b));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // shared tally behind the typed compares
  task automatic note(logic ok, logic [23:0] g, logic [23:0] e);
    total_checks++;
    if (!ok)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_crit(flj_crit_s g, flj_crit_s e);
    note(g === e, 24'(g), 24'(e));
  endtask
  task automatic chk_val(flj_val_t g, flj_val_t e);
    note(g === e, 24'(g), 24'(e));
  endtask
  task automatic chk_bank(flj_bank_t g, flj_bank_t e);
    note(g === e, 24'(g), 24'(e));
  endtask
  task automatic chk_flag(logic g, logic e);
    note(g === e, 24'(g), 24'(e));
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one valid sample; criteria are read once the update has landed
  task automatic sample(flj_val_t v, flj_crit_s e);
    meas <= '{1'b1, 1'b0, v};
    tick(1);
    meas.valid <= 1'b0;
    tick(1);
    chk_crit(crit, e);
  endtask
  task automatic press(logic [2:0] b);
    btns <= b;
    tick(1);
    btns <= 3'h0;
    tick(1);
  endtask
  task automatic capture(flj_val_t v);
    meas.value <= v;
    press(3'h4);
  endtask
  task automatic step();
    mode_held <= 1'b1;
    press(3'h1);
    mode_held <= 1'b0;
  endtask
  // bounded wait; an overrun ends the run
  task automatic wait_bank(flj_bank_t e);
    for (int i = 0; i < 60 && bank !== e; i++)
      tick(1);
    chk_bank(bank, e);
    if (bank !== e)
      wrap_up();
  endtask

  task automatic t_levels();
    sample(22'sd80000, 5'h10);
    sample(22'sd70000, 5'h08);
    sample(22'sd50000, 5'h04);
    sample(22'sd10000, 5'h04);
    sample(22'sd0, 5'h02);
    sample(-22'sd10000, 5'h02);
    sample(-22'sd10001, 5'h01);
    sample(22'sd70001, 5'h10);
    $display("done levels");
  endtask
  task automatic t_edit();
    press(3'h2);
    sample(22'sd70000, 5'h10);
    press(3'h1);
    sample(22'sd70000, 5'h08);
    five_mode <= 1'b0;
    press(3'h2);
    press(3'h4);
    chk_flag(refused, 1'b1);
    sample(22'sd80000, 5'h08);
    five_mode <= 1'b1;
    sample(22'sd70000, 5'h08);
    $display("done edit");
  endtask
  // midpoints floor toward minus; a refused set must not start a pair
  task automatic t_cal();
    capture(22'sd60000);
    capture(22'sd100001);
    sample(22'sd80000, 5'h08);
    sample(22'sd80001, 5'h10);
    edit_sel <= FLJ_SEL_LA;
    capture(22'sd0);
    capture(-22'sd40001);
    sample(-22'sd20001, 5'h02);
    sample(-22'sd20002, 5'h01);
    meas.invalid <= 1'b1;
    press(3'h4);
    chk_flag(refused, 1'b1);
    meas.valid <= 1'b1;
    tick(1);
    meas.valid <= 1'b0;
    meas.invalid <= 1'b0;
    tick(1);
    chk_crit(crit, 5'h00);
    chk_flag(disp_inv, 1'b1);
    capture(-22'sd10000);
    capture(-22'sd10000);
    sample(-22'sd10001, 5'h01);
    $display("done cal");
  endtask
  task automatic t_invert();
    edit_sel <= FLJ_SEL_UA;
    capture(-22'sd30000);
    capture(-22'sd30000);
    sample(-22'sd20000, 5'h11);
    sample(22'sd60000, 5'h10);
    sample(22'sd30000, 5'h10);
    sample(-22'sd40000, 5'h01);
    capture(22'sd70000);
    capture(22'sd70000);
    edit_sel <= FLJ_SEL_LA;
    capture(22'sd20000);
    capture(22'sd20000);
    sample(22'sd15000, 5'h01);
    sample(22'sd30000, 5'h04);
    capture(-22'sd10000);
    capture(-22'sd10000);
    $display("done invert");
  endtask
  task automatic t_preset();
    edit_sel <= FLJ_SEL_PVL;
    repeat (3) press(3'h1);
    sample(22'sd0, 5'h02);
    chk_val(disp, 22'sd3);
    sample(22'sd49997, 5'h04);
    sample(22'sd49998, 5'h08);
    repeat (3) press(3'h2);
    $display("done preset");
  endtask
  task automatic t_bank();
    int w;
    w = wr_seen;
    step();
    chk_bank(bank, 2'h3);
    edit_sel <= FLJ_SEL_UA;
    press(3'h2);
    sample(22'sd70000, 5'h10);
    step();
    chk_bank(bank, 2'h0);
    sample(22'sd70000, 5'h08);
    chk_flag(wr_seen > w, 1'b1);
    key_locked <= 1'b1;
    step();
    chk_bank(bank, 2'h0);
    for (int b = 0; b < 4; b++)
    begin
      want <= 2'(b + 2);
      wait_bank(2'(b + 2));
    end
    key_locked <= 1'b0;
    want <= 2'h2;
    tick(30);
    chk_bank(bank, 2'h1);
    $display("done bank");
  endtask
  // preset point per bank or shared; arrows also reach high and low
  task automatic t_share();
    edit_sel <= FLJ_SEL_PPT;
    press(3'h1);
    tick(1);
    chk_val(ppt, 22'sd1);
    shared <= 1'b1;
    repeat (2) press(3'h1);
    tick(1);
    chk_val(ppt, 22'sd2);
    shared <= 1'b0;
    tick(2);
    chk_val(ppt, 22'sd1);
    edit_sel <= FLJ_SEL_HI;
    press(3'h2);
    sample(22'sd50000, 5'h08);
    edit_sel <= FLJ_SEL_LO;
    press(3'h1);
    sample(22'sd10000, 5'h02);
    $display("done share");
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    nv_valid <= 1'b1;
    tick(1);
    nv_valid <= 1'b0;
    tick(2);
    chk_bank(bank, 2'h2);
    chk_crit(crit, 5'h00);
    t_levels();
    t_edit();
    t_cal();
    t_invert();
    t_preset();
    t_bank();
    t_share();
    wrap_up();
  end
endmodule // flj_judge_bench
`default_nettype wire
